/* File: esr_pkg.sv */
// constants, state codes and carriers for the erase suspend/resume controller
// Functional notes
// - Write-in-progress reads 1 while the self-timed erase runs and 0 once it has finished.
// - While suspended, reads and programs are allowed everywhere except the big block erased.
// - A suspend waits the suspend latency, then clears the write enable latch and sets the flag.
// - After the latency, reads, write enable/disable, wrap setting and ID reads are accepted.
// - After the latency, security and parameter reads, page programs and resume are accepted.
// - Status reads, reset-enable and reset are accepted at any time after a suspend.
// - The suspend flag is status bit 15: 1 while an erase is suspended, 0 once it is resumed.
// - Resume is accepted only when the suspend flag is 1 and write-in-progress is 0.
// - An accepted resume clears the flag at once and sets write-in-progress within 200 ns.
// - A resume while the flag is 0 or write-in-progress is 1 is ignored, changing nothing.
package esr_pkg;

  // opcodes the controller itself acts on
  localparam logic [7:0] OP_SUSPEND  = 8'h75;
  localparam logic [7:0] OP_RESUME   = 8'h7a;

  // array address layout; big block is the 64KB field
  localparam int ADDR_W  = 24;
  localparam int BLK_LSB = 16;
  localparam int BLK_W   = ADDR_W - BLK_LSB;
  localparam int SUS_STATUS_BIT = 15;

  // timing at the core clock
  localparam int CLK_PERIOD_PS         = 4000;
  localparam int SUSPEND_LATENCY_NS    = 20000;
  localparam int SUSPEND_LATENCY_CYC   = (SUSPEND_LATENCY_NS * 1000 + CLK_PERIOD_PS - 1)
                                         / CLK_PERIOD_PS;
  localparam int RESUME_WIP_MAX_NS     = 200;
  localparam int RESUME_WIP_MAX_CYC    = (RESUME_WIP_MAX_NS * 1000) / CLK_PERIOD_PS;

  // reset values
  localparam logic RST_SUS = 1'b0;
  localparam logic RST_WIP = 1'b0;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h1,
    ST_ERASE     = 4'h2,
    ST_SUSP_WAIT = 4'h4,
    ST_SUSPENDED = 4'h8
  } erase_state_t;

  // decoded instruction byte, one-cycle valid
  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } op_req_t;

  // array read/program address check, one-cycle valid
  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } acc_req_t;

  // opcode classes while suspended
  typedef struct packed {
    logic exempt;
    logic post_latency;
  } op_class_t;

endpackage

/* File: esr_op_class.sv */
// opcode classifier for the suspended-erase instruction filter
`timescale 1ns/100ps
`default_nettype none
module esr_op_class (
  // opcode in
  input  wire logic [7:0]         code_i,
  // class out
  output esr_pkg::op_class_t      cls_o
);
  import esr_pkg::*;

  // pure lookup; two small tables keep the timing path short
  always_comb begin
    cls_o = '0;
    unique case (code_i)
      8'h05, 8'h35, 8'h15, 8'h66, 8'h99: cls_o.exempt = 1'b1;
      8'h06, 8'h04, 8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb,
      8'he7, 8'h77, 8'h90, 8'h92, 8'h94, 8'h9f, 8'h4b, 8'hab:
        cls_o.post_latency = 1'b1;
      8'h48, 8'h5a, 8'h02, 8'h32, OP_RESUME: cls_o.post_latency = 1'b1;
      default: cls_o = '0;
    endcase
  end

endmodule // esr_op_class
`default_nettype wire

/* File: erase_suspend_resume_ctrl.sv */
// erase suspend/resume sequencer with instruction and region filtering
`timescale 1ns/100ps
`default_nettype none
module erase_suspend_resume_ctrl #(
  parameter int SUSPEND_LATENCY_CYC = esr_pkg::SUSPEND_LATENCY_CYC
) (
  // clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      nrst_i,
  // erase engine
  input  wire logic                      erase_start_i,
  input  wire logic [esr_pkg::ADDR_W-1:0] erase_addr_i,
  input  wire logic                      erase_done_i,
  input  wire logic                      prog_busy_i,
  output logic                           engine_run_o,
  // instruction decoder
  input  wire esr_pkg::op_req_t          op_i,
  output logic                           op_accept_o,
  output logic                           op_reject_o,
  // array access check
  input  wire esr_pkg::acc_req_t         acc_i,
  output logic                           acc_grant_o,
  output logic                           acc_deny_o,
  // status
  output logic                           write_in_progress_o,
  output logic                           erase_suspended_flag_o,
  output logic                           wel_clear_o
);
  import esr_pkg::*;

  localparam int CW = $clog2(SUSPEND_LATENCY_CYC + 1);
  localparam logic [CW-1:0] LAT_LOAD = CW'(SUSPEND_LATENCY_CYC - 1);
  localparam int WIP_MAX = RESUME_WIP_MAX_CYC;

  typedef struct packed {
    erase_state_t     st;
    logic [CW-1:0]    cnt;
    logic [BLK_W-1:0] blk;
    logic             erase_suspended_flag;
    logic             erase_wip;
    logic             write_in_progress;
    logic             wel_clr;
    logic             run;
    logic             acc;
    logic             rej;
    logic             grant;
    logic             deny;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;
  op_class_t   cls;
  logic        ok;
  logic        resume_ok;
  logic        same_blk;

  esr_op_class u_op_class (
    .code_i (op_i.code),
    .cls_o  (cls)
  );

  // resume only with flag set and nothing writing
  assign resume_ok = (s_q.st == ST_SUSPENDED) && s_q.erase_suspended_flag && !(s_q.erase_wip || prog_busy_i);
  assign same_blk  = (acc_i.addr[ADDR_W-1:BLK_LSB] == s_q.blk);

  // instruction filter by phase of the erase
  always_comb begin
    ok = 1'b0;
    unique case (s_q.st)
      ST_IDLE:      ok = (op_i.code != OP_SUSPEND) && (op_i.code != OP_RESUME);
      ST_ERASE:     ok = (op_i.code != OP_RESUME);
      ST_SUSP_WAIT: ok = cls.exempt;
      ST_SUSPENDED: begin
        if (op_i.code == OP_RESUME) begin
          ok = resume_ok;
        end else begin
          ok = cls.exempt || cls.post_latency;
        end
      end
    endcase
  end

  // next state
  always_comb begin
    s_d         = s_q;
    s_d.wel_clr = 1'b0;
    s_d.acc     = op_i.valid && ok;
    s_d.rej     = op_i.valid && !ok;
    s_d.grant   = 1'b0;
    s_d.deny    = 1'b0;
    unique case (s_q.st)
      ST_IDLE: begin
        s_d.grant = acc_i.valid;
        if (erase_start_i) begin
          s_d.st        = ST_ERASE;
          s_d.blk       = erase_addr_i[ADDR_W-1:BLK_LSB];
          s_d.erase_wip = 1'b1;
        end
      end
      ST_ERASE: begin
        s_d.deny = acc_i.valid;
        if (erase_done_i) begin
          s_d.st        = ST_IDLE;
          s_d.erase_wip = 1'b0;
        end else if (op_i.valid && op_i.code == OP_SUSPEND) begin
          s_d.st  = ST_SUSP_WAIT;
          s_d.cnt = LAT_LOAD;
        end
      end
      ST_SUSP_WAIT: begin
        // engine already stopped; a finish in flight still wins
        s_d.deny = acc_i.valid;
        if (erase_done_i) begin
          s_d.st        = ST_IDLE;
          s_d.erase_wip = 1'b0;
        end else if (s_q.cnt == '0) begin
          s_d.st        = ST_SUSPENDED;
          s_d.erase_suspended_flag       = 1'b1;
          s_d.wel_clr   = 1'b1;
          s_d.erase_wip = 1'b0;
        end else begin
          s_d.cnt = s_q.cnt - CW'(1);
        end
      end
      ST_SUSPENDED: begin
        s_d.grant = acc_i.valid && !same_blk;
        s_d.deny  = acc_i.valid && same_blk;
        if (op_i.valid && op_i.code == OP_RESUME && resume_ok) begin
          s_d.st        = ST_ERASE;
          s_d.erase_suspended_flag       = 1'b0;
          s_d.erase_wip = 1'b1;
        end
      end
    endcase
    s_d.run = (s_d.st == ST_ERASE);
    s_d.write_in_progress = s_d.erase_wip || prog_busy_i;
  end

  // single state register
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      s_q           <= '0;
      s_q.st        <= ST_IDLE;
      s_q.erase_suspended_flag       <= RST_SUS;
      s_q.erase_wip <= RST_WIP;
      s_q.write_in_progress       <= RST_WIP;
    end else begin
      s_q <= s_d;
    end
  end

  assign engine_run_o           = s_q.run;
  assign op_accept_o            = s_q.acc;
  assign op_reject_o            = s_q.rej;
  assign acc_grant_o            = s_q.grant;
  assign acc_deny_o             = s_q.deny;
  assign write_in_progress_o    = s_q.write_in_progress;
  assign erase_suspended_flag_o = s_q.erase_suspended_flag;
  assign wel_clear_o            = s_q.wel_clr;

  // helper: cycles spent waiting for the suspend to settle
  logic [31:0] lat_cnt;
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      lat_cnt <= '0;
    end else if (s_q.st == ST_SUSP_WAIT) begin
      lat_cnt <= lat_cnt + 32'h1;
    end else begin
      lat_cnt <= '0;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  AST_ERASE_WIP_SET: assert property (
    (s_q.st == ST_IDLE && erase_start_i) |=> write_in_progress_o && engine_run_o)
    else $error("wip not set after erase start");
  AST_ERASE_WIP_CLR: assert property (
    (s_q.st == ST_ERASE && erase_done_i && !prog_busy_i) |=> !write_in_progress_o)
    else $error("wip not cleared after erase done");
  AST_SUSPEND_LATENCY: assert property (
    $rose(erase_suspended_flag_o)
      |-> wel_clear_o && ($past(lat_cnt) == 32'(SUSPEND_LATENCY_CYC - 1)))
    else $error("suspend flag timing wrong");
  AST_NO_EARLY_FLAG: assert property (
    (s_q.st == ST_ERASE && op_i.valid && op_i.code == OP_SUSPEND && !erase_done_i)
      |=> !erase_suspended_flag_o [*2])
    else $error("suspend flag set before latency");
  AST_EXEMPT_ANYTIME: assert property (
    (s_q.st == ST_SUSP_WAIT && op_i.valid && cls.exempt) |=> op_accept_o && !op_reject_o)
    else $error("exempt opcode refused during latency");
  AST_EARLY_REFUSE: assert property (
    (s_q.st == ST_SUSP_WAIT && op_i.valid && !cls.exempt) |=> op_reject_o)
    else $error("opcode taken before latency elapsed");
  AST_POST_LATENCY: assert property (
    (s_q.st == ST_SUSPENDED && op_i.valid && cls.post_latency && op_i.code != OP_RESUME)
      |=> op_accept_o)
    else $error("listed opcode refused while suspended");
  AST_REGION_DENY: assert property (
    (s_q.st == ST_SUSPENDED && acc_i.valid)
      |=> (acc_deny_o == ($past(acc_i.addr[ADDR_W-1:BLK_LSB]) == $past(s_q.blk)))
        && (acc_grant_o != acc_deny_o))
    else $error("region check wrong while suspended");
  AST_RESUME_TAKEN: assert property (
    (op_i.valid && op_i.code == OP_RESUME && resume_ok)
      |=> !erase_suspended_flag_o ##0 op_accept_o ##[0:WIP_MAX] write_in_progress_o)
    else $error("resume did not restart erase");
  AST_RESUME_IGNORED: assert property (
    (op_i.valid && op_i.code == OP_RESUME && !resume_ok
      && !(s_q.st == ST_SUSP_WAIT && s_q.cnt == '0))
      |=> op_reject_o && (erase_suspended_flag_o == $past(erase_suspended_flag_o)))
    else $error("ignored resume changed state");
  AST_RUN_PAUSED: assert property (
    (s_q.st == ST_ERASE && op_i.valid && op_i.code == OP_SUSPEND && !erase_done_i)
      |=> !engine_run_o && op_accept_o && write_in_progress_o)
    else $error("erase engine not paused by suspend");
  // a finish racing the latency must leave no suspend behind
  AST_SUSPEND_ABORT: assert property (
    (s_q.st == ST_SUSP_WAIT && erase_done_i)
      |=> !erase_suspended_flag_o && !engine_run_o
        && (write_in_progress_o == $past(prog_busy_i)))
    else $error("finished erase not closed during latency");

  COV_SUSPENDED: cover property ($rose(erase_suspended_flag_o));
  COV_RESUMED:   cover property (s_q.st == ST_SUSPENDED ##1 s_q.st == ST_ERASE);
  COV_DENIED:    cover property (acc_deny_o && erase_suspended_flag_o);
  COV_FINISHED:  cover property (s_q.st == ST_ERASE && erase_done_i && !$past(s_q.erase_suspended_flag) ##0 1'b1);
  COV_ABORTED:   cover property (s_q.st == ST_SUSP_WAIT && erase_done_i);

endmodule // erase_suspend_resume_ctrl
`default_nettype wire

/* File: host_op_model.sv */
// host-side model: turns a send request into a one-cycle opcode strobe
`timescale 1ns/100ps
`default_nettype none
module host_op_model (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  // request from the bench
  input  wire logic         send_i,
  input  wire logic [7:0]   code_i,
  // strobe to the controller
  output esr_pkg::op_req_t  op_o
);
  // one whole byte per strobe; code inverted on every idle cycle, so a stale byte comes back every other cycle
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      op_o <= '0;
    end else begin
      op_o.valid <= send_i;
      op_o.code  <= send_i ? code_i : ~op_o.code;
    end
  end
endmodule // host_op_model
`default_nettype wire

/* File: test_erase_suspend_resume_ctrl.sv */
// self-checking bench for the erase suspend/resume controller
`timescale 1ns/100ps
`default_nettype none
module test_erase_suspend_resume_ctrl;
  import esr_pkg::*;
  localparam int LAT = 12; // short latency keeps the run brief
  logic              core_clk, nrst, erase_start, erase_done, prog_busy, send, clr_seen;
  logic [ADDR_W-1:0] erase_addr;
  logic [7:0]        code, blk, c;
  op_req_t           op;
  acc_req_t          acc;
  logic              op_acc, op_rej, acc_gr, acc_dn, run, wr_busy, flag, clr;
  int                n_mismatch, checks, ph;
  logic [7:0] ok_codes [$] = '{8'h06, 8'h04, 8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb,
    8'he7, 8'h77, 8'h90, 8'h92, 8'h94, 8'h9f, 8'h4b, 8'hab, 8'h48, 8'h5a, 8'h02, 8'h32,
    8'h05, 8'h35, 8'h15, 8'h66, 8'h99};

  // free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  erase_suspend_resume_ctrl #(.SUSPEND_LATENCY_CYC(LAT)) u_dut (
    .core_clk_i(core_clk), .nrst_i(nrst), .erase_start_i(erase_start),
    .erase_addr_i(erase_addr), .erase_done_i(erase_done), .prog_busy_i(prog_busy),
    .engine_run_o(run), .op_i(op), .op_accept_o(op_acc), .op_reject_o(op_rej),
    .acc_i(acc), .acc_grant_o(acc_gr), .acc_deny_o(acc_dn), .write_in_progress_o(wr_busy),
    .erase_suspended_flag_o(flag), .wel_clear_o(clr));
  host_op_model u_host (.clk_i(core_clk), .nrst_i(nrst), .send_i(send), .code_i(code),
    .op_o(op));

  // latch clear is a one-cycle pulse, so remember it
  always @(posedge core_clk) begin
    if (clr) clr_seen <= 1'b1;
  end

  // expected verdict by phase: 0 idle, 1 erase, 2 latency wait, 3 suspended
  function automatic logic op_ok(int p, logic [7:0] k);
    logic ex;
    ex = k inside {8'h05, 8'h35, 8'h15, 8'h66, 8'h99};
    case (p)
      0: return k != OP_SUSPEND && k != OP_RESUME;
      1: return k != OP_RESUME;
      2: return ex;
      default: return ex || (k inside {ok_codes}) || (k == OP_RESUME && !prog_busy);
    endcase
  endfunction

  function automatic logic pick(int w);
    case (w)
      0: return flag;
      1: return wr_busy;
      default: return run;
    endcase
  endfunction

  task automatic chk(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %b got %b", nm, e, g);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // strobe reaches the controller two edges on, verdict one edge later
  task automatic send_op(input logic [7:0] k);
    logic e;
    @(posedge core_clk);
    send <= 1'b1;
    code <= k;
    // expectation taken once a busy level driven on the last edge has settled
    e = op_ok(ph, k);
    @(posedge core_clk);
    send <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("op_accept", e, op_acc);
    chk("op_reject", !e, op_rej);
  endtask

  task automatic access(input logic [ADDR_W-1:0] a, input logic e);
    @(posedge core_clk);
    acc <= '{1'b1, a};
    @(posedge core_clk);
    acc.valid <= 1'b0;
    #1;
    chk("acc_grant", e, acc_gr);
    chk("acc_deny", !e, acc_dn);
  endtask

  task automatic wait_for(input int w, input logic v, input int mx);
    int i;
    #1;
    for (i = 0; i < mx && pick(w) !== v; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk("wait_level", v, pick(w));
    if (pick(w) !== v) end_sim();
  endtask

  // main sequence
  initial begin
    {nrst, erase_start, erase_done, prog_busy, send, clr_seen} = '0;
    {code, erase_addr, acc, n_mismatch, checks, ph} = '0;
    void'($urandom(32'hd4f97d8c));
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    #1;
    chk("flag_rst", 1'b0, flag);
    chk("run_rst", 1'b0, run);
    $display("test reset done");
    send_op(OP_RESUME);
    send_op(OP_SUSPEND);
    repeat (8) send_op(8'($urandom));
    access(24'($urandom), 1'b1);
    chk("flag_idle", 1'b0, flag);
    $display("test idle done");
    blk = 8'($urandom);
    @(posedge core_clk);
    erase_addr <= {blk, 16'($urandom)};
    erase_start <= 1'b1;
    @(posedge core_clk);
    erase_start <= 1'b0;
    ph = 1;
    wait_for(1, 1'b1, 4);
    send_op(OP_RESUME);
    access({blk + 8'h01, 16'h0000}, 1'b0);
    send_op(OP_SUSPEND);
    ph = 2;
    send_op(8'h05);
    send_op(8'h03);
    access({~blk, 16'($urandom)}, 1'b0);
    chk("flag_early", 1'b0, flag);
    chk("wel_early", 1'b0, clr_seen);
    wait_for(0, 1'b1, LAT);
    ph = 3;
    chk("wel_clear", 1'b1, clr_seen | clr);
    chk("busy_susp", 1'b0, wr_busy);
    foreach (ok_codes[i]) send_op(ok_codes[i]);
    repeat (8) begin
      c = 8'($urandom);
      send_op(c == OP_RESUME ? 8'h20 : c);
    end
    access({blk, 16'($urandom)}, 1'b0);
    access({~blk, 16'($urandom)}, 1'b1);
    $display("test suspend done");
    @(posedge core_clk);
    prog_busy <= 1'b1;
    send_op(OP_RESUME);
    chk("flag_kept", 1'b1, flag);
    @(posedge core_clk);
    prog_busy <= 1'b0;
    wait_for(1, 1'b0, 4);
    send_op(OP_RESUME);
    chk("flag_resume", 1'b0, flag);
    ph = 1;
    wait_for(1, 1'b1, 50);
    chk("run_resume", 1'b1, run);
    @(posedge core_clk);
    erase_done <= 1'b1;
    @(posedge core_clk);
    erase_done <= 1'b0;
    wait_for(1, 1'b0, 4);
    $display("test resume done");
    // suspend cut short by the erase finishing inside the latency
    @(posedge core_clk);
    erase_start <= 1'b1;
    @(posedge core_clk);
    erase_start <= 1'b0;
    send_op(OP_SUSPEND);
    @(posedge core_clk);
    erase_done <= 1'b1;
    @(posedge core_clk);
    erase_done <= 1'b0;
    wait_for(1, 1'b0, 4);
    repeat (LAT) @(posedge core_clk);
    #1;
    chk("flag_abort", 1'b0, flag);
    chk("run_abort", 1'b0, run);
    $display("test abort done");
    end_sim();
  end
endmodule // test_erase_suspend_resume_ctrl
`default_nettype wire
